// ---- core/csf_pkg.sv ----
/*
 Shared constants and types for the core status and option register bank.
 Assumes a single 100 MHz clock and a synchronous active-high reset.
*/
package csf_pkg;
   // ***************************************************************
   // Register map
   // ***************************************************************
   localparam logic [7:0] STATUS_ADDR_B0 = 8'h03;
   localparam logic [7:0] STATUS_ADDR_B1 = 8'h83;
   localparam logic [7:0] OPTION_ADDR = 8'h81;
   localparam logic [7:0] BANK1_BASE = 8'h80;
   // ***************************************************************
   // Field positions of the status register and the option prescaler assign bit
   // ***************************************************************
   localparam int CARRY_POS = 0;
   localparam int NIBBLE_POS = 1;
   localparam int ZERO_POS = 2;
   localparam int PD_POS = 3;
   localparam int TO_POS = 4;
   localparam int BANK_LOW_POS = 5;
   localparam int BANK_HIGH_POS = 6;
   localparam int INDIRECT_POS = 7;
   localparam int PSA_POS = 3;
   // ***************************************************************
   // Reset values
   // ***************************************************************
   localparam logic [7:0] OPTION_RESET = 8'hFF;
   localparam logic [2:0] STATUS_UPPER_RESET = 3'h0;
   localparam logic [7:0] CLEAR_FILE_MASK = 8'h18;
   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic [3:0] {
      CSF_OP_NONE = 4'h1,
      CSF_OP_ADD = 4'h2,
      CSF_OP_SUB = 4'h4,
      CSF_OP_LOGIC = 4'h8
   } csf_op_e;
   typedef struct packed {
      logic zero;
      logic nibble_carry;
      logic carry;
   } csf_flags_s;
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] data;
      logic clear_file;
      logic flags_upd;
   } csf_write_s;
endpackage

// ---- core/csf_alu_flags.sv ----
/*
 Flag generator for one ALU operation on two 8-bit operands.
 Assumes the operand pair and operation select are stable within a cycle.
*/
module csf_alu_flags
   import csf_pkg::*;
(
   // Operation
   input wire csf_pkg::csf_op_e op_i,
   input wire logic [7:0] a_i,
   input wire logic [7:0] b_i,
   input wire logic [7:0] logic_res_i,
   // Result
   output logic [7:0] result_o,
   output csf_pkg::csf_flags_s flags_o
);
   wire [8:0] sum9 = {1'b0, a_i} + {1'b0, b_i};
   // Subtraction adds the two's complement, so carry out means no borrow.
   wire [8:0] dif9 = {1'b0, a_i} + {1'b0, ~b_i} + 9'h001;
   wire [4:0] nsum = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
   wire [4:0] ndif = {1'b0, a_i[3:0]} + {1'b0, ~b_i[3:0]} + 5'h01;
   wire is_sub = (op_i == CSF_OP_SUB);
   wire is_logic = (op_i == CSF_OP_LOGIC);
   assign result_o = is_logic ? logic_res_i : (is_sub ? dif9[7:0] : sum9[7:0]);
   assign flags_o.zero = (result_o == 8'h00);
   assign flags_o.carry = is_sub ? dif9[8] : sum9[8];
   assign flags_o.nibble_carry = is_sub ? ndif[4] : nsum[4];
endmodule

// ---- core/csf_status_bank.sv ----
/*
 Status and option register bank of the small processor core.
 Assumes the execution unit presents one write per cycle with decoded flags.
*/
// Behaviour
// - Flag-updating writes to status ignore written zero, nibble and carry bits.
// - Status accepts writes from any instruction like a file register.
// - Instruction writes never change time-out or power-down flags.
// - Clear-file on status zeroes upper three bits, sets zero, keeps others.
// - Bank select low bit picks bank 0 or bank 1 at 80h.
// - Time-out set at power-up, watchdog clear, sleep; cleared on time-out.
// - Power-down set at power-up or watchdog clear; cleared by sleep.
// - Subtract carry and nibble carry are inverted borrows.
// - Option register is fully readable and writable.
// - Prescaler assign bit set gives watchdog prescaler, timer at 1:1.
module csf_status_bank
   import csf_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Register write port and read address
   input wire csf_pkg::csf_write_s wr_i,
   input wire logic [7:0] rd_addr_i,
   // ALU operands
   input wire csf_pkg::csf_op_e op_i,
   input wire logic [7:0] a_i,
   input wire logic [7:0] b_i,
   input wire logic [7:0] logic_res_i,
   // Reset-cause events
   input wire logic wdt_clear_i,
   input wire logic sleep_i,
   input wire logic wdt_timeout_i,
   // Direct addressing
   input wire logic [6:0] direct_addr_i,
   // Outputs
   output logic [7:0] rd_data_o,
   output logic [7:0] alu_result_o,
   output logic [7:0] status_o,
   output logic [7:0] option_o,
   output logic [7:0] direct_full_addr_o,
   output logic wdt_has_prescaler_o,
   output logic timer_prescaled_o
);
   import csf_pkg::*;
   // ***************************************************************
   // State
   // ***************************************************************
   logic [7:0] status;
   logic [7:0] option;
   csf_flags_s flags;
   logic [7:0] next_status;
   logic [7:0] next_option;

   csf_alu_flags u_alu (
      .op_i(op_i),
      .a_i(a_i),
      .b_i(b_i),
      .logic_res_i(logic_res_i),
      .result_o(alu_result_o),
      .flags_o(flags)
   );

   function automatic logic is_status(input logic [7:0] a);
      is_status = (a == STATUS_ADDR_B0) || (a == STATUS_ADDR_B1);
   endfunction

   wire st_wr = wr_i.wr && is_status(wr_i.addr);
   wire opt_wr = wr_i.wr && (wr_i.addr == OPTION_ADDR);
   wire flags_live = (op_i != CSF_OP_NONE) && wr_i.flags_upd;
   // ***************************************************************
   // Next-state decoding
   // ***************************************************************
   wire [7:0] wdata = wr_i.clear_file ? 8'h00 : wr_i.data;
   // Clear-file must leave nibble carry and carry alone, so it keeps the old flags.
   wire [2:0] wr_flags = wr_i.clear_file ? status[2:0] : wdata[2:0];
   // Flags from the ALU win over the written value on the same write.
   wire [2:0] flag_bits = flags_live ? {flags.zero, flags.nibble_carry, flags.carry}
      : (st_wr ? wr_flags : status[2:0]);
   wire [2:0] upper = st_wr ? wdata[7:5] : status[7:5];
   // Watchdog time-out beats the set events arriving in the same cycle.
   wire to_bit = wdt_timeout_i ? 1'b0 : ((wdt_clear_i || sleep_i) ? 1'b1 : status[TO_POS]);
   wire pd_bit = sleep_i ? 1'b0 : (wdt_clear_i ? 1'b1 : status[PD_POS]);
   // Clear-file on status forces zero through the flag path even with no ALU op.
   wire zero_fix = (st_wr && wr_i.clear_file) ? 1'b1 : flag_bits[2];
   assign next_status = {upper, to_bit, pd_bit, zero_fix, flag_bits[1:0]};
   assign next_option = opt_wr ? wr_i.data : option;

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         status <= CLEAR_FILE_MASK;
         option <= OPTION_RESET;
      end else begin
         status <= next_status;
         option <= next_option;
      end
   end
   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign status_o = status;
   assign option_o = option;
   wire rd_is_option = (rd_addr_i == OPTION_ADDR);
   assign rd_data_o = is_status(rd_addr_i) ? status
      : (rd_is_option ? option : 8'h00);
   assign direct_full_addr_o = status[BANK_LOW_POS] ? (BANK1_BASE | {1'b0, direct_addr_i})
      : {1'b0, direct_addr_i};
   assign wdt_has_prescaler_o = option[PSA_POS];
   assign timer_prescaled_o = ~option[PSA_POS];
   // ***************************************************************
   // Checks
   // ***************************************************************
   a_flag_mask_alu: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      st_wr && flags_live |=> status[0] == $past(flags.carry)
      && status[2] == $past(flags.zero))
      else $error("status flags took the written value");
   a_cause_no_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      st_wr && !wdt_clear_i && !sleep_i && !wdt_timeout_i |=> $stable(status[4:3]))
      else $error("cause flags changed by a write");
   a_clear_file_pat: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      st_wr && wr_i.clear_file && !flags_live |=> status[7:5] == 3'h0 && status[2])
      else $error("clear of status wrong");
   a_timeout_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      wdt_timeout_i |=> !status[4])
      else $error("time-out flag not cleared");
   a_sleep_cause: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      sleep_i && !wdt_timeout_i |=> status[4] && !status[3])
      else $error("sleep flags wrong");
   a_bank_map: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      direct_full_addr_o[7] == status[5])
      else $error("bank select wrong");
   a_option_rw: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      opt_wr |=> option == $past(wr_i.data))
      else $error("option write lost");
   a_sub_borrow: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      op_i == CSF_OP_SUB |-> flags.carry == (a_i >= b_i))
      else $error("borrow polarity wrong");
   a_prescale_sel: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      option[3] |-> wdt_has_prescaler_o && !timer_prescaled_o)
      else $error("prescaler assignment wrong");

   // A clear-file write must not disturb the two carry flags.
   a_clear_keeps_carry: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      st_wr && wr_i.clear_file && !flags_live |=> status[1:0] == $past(status[1:0]))
      else $error("clear of status changed carry flags");

   a_alu_flags_land: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      flags_live && !(st_wr && wr_i.clear_file)
      |=> status[2:0] == $past({flags.zero, flags.nibble_carry, flags.carry}))
      else $error("ALU flags not stored");

   a_plain_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      st_wr && !flags_live && !wr_i.clear_file
      |=> status[7:5] == $past(wr_i.data[7:5]) && status[2:0] == $past(wr_i.data[2:0]))
      else $error("plain status write lost");

   a_wdt_clear_sets: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      wdt_clear_i && !sleep_i && !wdt_timeout_i |=> status[4:3] == 2'b11)
      else $error("watchdog clear did not set cause flags");

   // Without an event the cause flags must hold, whatever else is written.
   a_to_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !wdt_timeout_i && !wdt_clear_i && !sleep_i |=> status[4] == $past(status[4]))
      else $error("time-out flag moved without event");

   a_pd_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !wdt_clear_i && !sleep_i |=> status[3] == $past(status[3]))
      else $error("power-down flag moved without event");

   a_option_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !opt_wr |=> $stable(option))
      else $error("option changed without write");

   a_read_status: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      is_status(rd_addr_i) |-> rd_data_o == status)
      else $error("status read wrong");

   a_read_option: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      rd_is_option |-> rd_data_o == option)
      else $error("option read wrong");

   a_bank_offset: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      direct_full_addr_o[6:0] == direct_addr_i)
      else $error("direct address offset wrong");

   a_add_carry: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      op_i == CSF_OP_ADD |-> flags.carry == (({1'b0, a_i} + {1'b0, b_i}) > 9'h0FF))
      else $error("add carry wrong");
endmodule

// ---- testbench/csf_core_model.sv ----
/* Core-side model: register writes, ALU operands and reset-cause events.
   Assumes the bank samples every input on the rising clock edge. */
module csf_core_model
   import csf_pkg::*;
(
   // Clock
   input wire logic clk_i,
   // Execution side
   output csf_pkg::csf_write_s wr_o,
   output csf_pkg::csf_op_e op_o,
   output logic [7:0] a_o,
   output logic [7:0] b_o,
   output logic [7:0] lres_o,
   output logic [2:0] ev_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      wr_o = '0;
      op_o = CSF_OP_NONE;
      {a_o, b_o, lres_o} = 24'h0;
      ev_o = 3'h0;
   end
   // Idle data is inverted so a stale bus never looks like a valid write.
   task automatic xfer(input logic [7:0] ad, dt, input logic cf, fu,
                       input csf_op_e o, input logic [7:0] x, y, l);
      @(posedge clk_i);
      #1;
      wr_o = '{1'b1, ad, dt & ((ad[6:0] == 7'h03) ? 8'h3F : 8'hFF), cf, fu};
      op_o = o;
      {a_o, b_o, lres_o} = {x, y, l};
      @(posedge clk_i);
      #1;
      wr_o.wr = 1'b0;
      wr_o.data = ~wr_o.data;
   endtask
   task automatic pulse(input logic [2:0] e);
      @(posedge clk_i);
      #1;
      ev_o = e;
      @(posedge clk_i);
      #1;
      ev_o = 3'h0;
   endtask
endmodule

// ---- testbench/testbench.sv ----
/* Self-checking bench for the status and option register bank.
   Assumes the core model drives every execution-side input. */
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import csf_pkg::*;
   typedef struct packed {
      logic [7:0] ad, dt;
      logic cf, fu;
      csf_op_e o;
      logic [7:0] x, y, ex;
   } csf_tv_s;
   logic sys_clk, rst, has_pre, tmr_pre;
   logic [7:0] rd_addr, rd_data, alu_res, status, option, full_addr, a, b, lres;
   logic [6:0] dir_addr;
   logic [2:0] ev;
   csf_write_s wr;
   csf_op_e op;
   int n_errors = 0;
   int num_checks = 0;
   logic [7:0] opts [2] = '{8'h37, 8'hC8};
   logic [2:0] evs [4] = '{3'h2, 3'h1, 3'h4, 3'h3};
   logic [7:0] evx [4] = '{8'h10, 8'h00, 8'h18, 8'h00};
   csf_tv_s tv [8] = '{'{8'h03, 8'h27, 0, 0, CSF_OP_NONE, 8'h00, 8'h00, 8'h3F},
      '{8'h83, 8'h00, 0, 1, CSF_OP_ADD, 8'h8F, 8'h71, 8'h1F},
      '{8'h03, 8'h07, 0, 1, CSF_OP_ADD, 8'h01, 8'h02, 8'h18},
      '{8'h03, 8'h00, 0, 1, CSF_OP_SUB, 8'h05, 8'h03, 8'h1B},
      '{8'h03, 8'h07, 0, 1, CSF_OP_SUB, 8'h03, 8'h05, 8'h18},
      '{8'h03, 8'h00, 0, 1, CSF_OP_SUB, 8'h10, 8'h01, 8'h19},
      '{8'h03, 8'h21, 0, 0, CSF_OP_NONE, 8'h00, 8'h00, 8'h39},
      '{8'h83, 8'h00, 1, 0, CSF_OP_NONE, 8'h00, 8'h00, 8'h1D}};
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   csf_core_model core (.clk_i(sys_clk), .wr_o(wr), .op_o(op), .a_o(a), .b_o(b),
      .lres_o(lres), .ev_o(ev));
   csf_status_bank dut (.sys_clk_i(sys_clk), .rst_i(rst), .wr_i(wr), .rd_addr_i(rd_addr),
      .op_i(op), .a_i(a), .b_i(b), .logic_res_i(lres), .wdt_clear_i(ev[2]),
      .sleep_i(ev[1]), .wdt_timeout_i(ev[0]), .direct_addr_i(dir_addr),
      .rd_data_o(rd_data), .alu_result_o(alu_res), .status_o(status), .option_o(option),
      .direct_full_addr_o(full_addr), .wdt_has_prescaler_o(has_pre),
      .timer_prescaled_o(tmr_pre));
   task automatic chk(input logic [7:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] ad, exp);
      rd_addr = ad;
      #1;
      chk(rd_data, exp);
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // A hang is cut short well after the few dozen cycles the tests need.
   initial begin
      #20000;
      n_errors++;
      complete_run();
   end
   initial begin
      rst = 1'b1;
      rd_addr = 8'h00;
      dir_addr = 7'h12;
      repeat (2) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      chk(status, 8'h18);
      rd(OPTION_ADDR, 8'hFF);
      rd(8'h05, 8'h00);
      $display("test reset done");
      foreach (opts[i]) begin
         core.xfer(OPTION_ADDR, opts[i], 0, 0, CSF_OP_NONE, 8'h00, 8'h00, 8'h00);
         rd(OPTION_ADDR, opts[i]);
         chk({7'h0, has_pre}, {7'h0, opts[i][PSA_POS]});
         chk({7'h0, tmr_pre}, {7'h0, ~opts[i][PSA_POS]});
      end
      $display("test option done");
      foreach (tv[i]) begin
         core.xfer(tv[i].ad, tv[i].dt, tv[i].cf, tv[i].fu, tv[i].o, tv[i].x, tv[i].y, 8'h00);
         rd(STATUS_ADDR_B1, tv[i].ex);
         chk(full_addr, {tv[i].ex[BANK_LOW_POS], dir_addr});
         if (tv[i].o == CSF_OP_SUB) chk(alu_res, tv[i].x - tv[i].y);
      end
      core.xfer(8'h05, 8'hFF, 0, 1, CSF_OP_LOGIC, 8'h12, 8'h34, 8'h5A);
      chk(alu_res, 8'h5A);
      rd(STATUS_ADDR_B0, 8'h18);
      $display("test status writes done");
      foreach (evs[i]) begin
         core.pulse(evs[i]);
         chk(status, evx[i]);
      end
      $display("test events done");
      complete_run();
   end
endmodule
